/* File: shared/ecnps_pkg.sv */
// package for the external bus pin steering block: constants and carriers
// assumes a 32-bit transfer address and active-low strobes throughout
package ecnps_pkg;

    // chip select windows (upper nibble of the transfer address)
    localparam logic [3:0] ECNPS_CS3_NIBBLE  = 4'h4;   // 0x4000_0000..0x4FFF_FFFF
    localparam logic [3:0] ECNPS_CS4_NIBBLE  = 4'h5;   // 0x5000_0000..0x5FFF_FFFF
    localparam logic [3:0] ECNPS_CS2_NIBBLE  = 4'h3;   // 0x3000_0000..0x3FFF_FFFF

    // address bit positions
    localparam int ECNPS_ALE_BIT   = 21;
    localparam int ECNPS_CLE_BIT   = 22;
    localparam int ECNPS_MODE_LSB  = 23;   // card mode field inside the slot window

    // card mode offsets within the slot window, bits [24:23]
    localparam logic [1:0] ECNPS_OFS_ATTR = 2'h0;
    localparam logic [1:0] ECNPS_OFS_COMM = 2'h1;
    localparam logic [1:0] ECNPS_OFS_IO   = 2'h2;
    localparam logic [1:0] ECNPS_OFS_IDE  = 2'h3;

    // static controller reset configuration
    localparam logic       ECNPS_RST_BYTE_SELECT = 1'b1;
    localparam logic [4:0] ECNPS_RST_BUS_WIDTH   = 5'h10;
    localparam logic       ECNPS_RST_CS_CTRL_RW  = 1'b1;

    typedef enum logic [2:0] {
        ECNPS_M_NONE = 3'b000,
        ECNPS_M_ATTR = 3'b001,
        ECNPS_M_COMM = 3'b010,
        ECNPS_M_IO   = 3'b011,
        ECNPS_M_IDE  = 3'b100
    } ecnps_mode_e;

    // strobes from the static controller, all active low
    typedef struct packed {
        logic read_strobe_n;
        logic write_strobe_n;
        logic upper_write_strobe_n;
        logic byte_select_three_n;
        logic chip_select_zero;
        logic chip_select_two;
        logic chip_select_three;
        logic chip_select_four;
    } ecnps_strb_s;

    // five time-shared pins
    typedef struct packed {
        logic oe_rd;
        logic we_wr0;
        logic ior_wr1;
        logic iow_bs3;
        logic rnw_cs0;
    } ecnps_pins_s;

endpackage

/* File: core/ecnps_mode_dec.sv */
// card access mode decoder for one slot window
// assumes address and select come from the same clock domain
`timescale 1ns/1ps
module ecnps_mode_dec
    import ecnps_pkg::*;
(
    // access
    input  wire logic [31:0] addr,
    input  wire logic        sel,
    // result
    output ecnps_mode_e      mode
);

    // mode taken from fixed offsets inside the window
    always_comb begin
        mode = ECNPS_M_NONE;
        if (sel) begin
            case (addr[ECNPS_MODE_LSB +: 2])
                ECNPS_OFS_ATTR: mode = ECNPS_M_ATTR;
                ECNPS_OFS_COMM: mode = ECNPS_M_COMM;
                ECNPS_OFS_IO:   mode = ECNPS_M_IO;
                default:        mode = ECNPS_M_IDE;
            endcase
        end
    end

endmodule // ecnps_mode_dec

/* File: core/ecnps_steer.sv */
// pin steering glue between the static controller and card / nand pins
// assumes strobes, address and wait pin are fed as described per group
`timescale 1ns/1ps
module ecnps_steer
    import ecnps_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RSTN,
    // assignment bits
    input  wire logic        SLOT0_ASSIGN_BIT,
    input  wire logic        SLOT1_ASSIGN_BIT,
    input  wire logic        NAND_ASSIGN_BIT,
    input  wire logic        SDRAM_ASSIGN_BIT,
    // static controller side
    input  wire logic [31:0] ADDR,
    input  ecnps_strb_s      STRB,
    output logic             STATIC_MEM_CTRL_WAIT_N,
    // pins
    input  wire logic        EXTERNAL_WAIT_N,
    output ecnps_pins_s      PINS,
    output logic             CARD_SLOT0_SELECT,
    output logic             CARD_SLOT1_SELECT,
    output logic             NAND_OUTPUT_ENABLE,
    output logic             NAND_WRITE_ENABLE,
    output logic             NAND_ALE,
    output logic             NAND_CLE,
    output logic             CARD_REG_SELECT_N,
    output logic             SDRAM_OWNS_CS1,
    // static controller reset config
    output logic             CFG_BYTE_SELECT,
    output logic [4:0]       CFG_BUS_WIDTH,
    output logic             CFG_CS_CTRL_RW
);

    ////////////////////////////////////////////////////////////////////
    // window decode
    function automatic logic in_win(input logic [31:0] a, input logic [3:0] nib);
        in_win = (a[31:28] == nib);
    endfunction

    logic        card0_acc;
    logic        card1_acc;
    logic        card_acc;
    logic        nand_acc;
    ecnps_mode_e mode0;
    ecnps_mode_e mode1;
    ecnps_mode_e mode;
    logic        io_like;

    // card access only while a slot is assigned and its select is low
    assign card0_acc = SLOT0_ASSIGN_BIT && in_win(ADDR, ECNPS_CS4_NIBBLE)
                       && !STRB.chip_select_four;
    assign card1_acc = SLOT1_ASSIGN_BIT && in_win(ADDR, ECNPS_CS2_NIBBLE) && !STRB.chip_select_two;
    assign card_acc  = card0_acc || card1_acc;
    // nand live only with its bit set and address inside cs3
    assign nand_acc  = NAND_ASSIGN_BIT && in_win(ADDR, ECNPS_CS3_NIBBLE)
                       && !STRB.chip_select_three;

    ecnps_mode_dec u_dec0 (
        .addr (ADDR),
        .sel  (card0_acc),
        .mode (mode0)
    );
    ecnps_mode_dec u_dec1 (
        .addr (ADDR),
        .sel  (card1_acc),
        .mode (mode1)
    );
    assign mode    = card0_acc ? mode0 : mode1;
    assign io_like = (mode == ECNPS_M_IO) || (mode == ECNPS_M_IDE);

    ////////////////////////////////////////////////////////////////////
    // wait synchroniser: pin passes two flops before use
    logic wait_s1_q;
    logic wait_s2_q;

    // card wait stretches the controller access
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            wait_s1_q <= 1'b1;
            wait_s2_q <= 1'b1;
        end else begin
            wait_s1_q <= EXTERNAL_WAIT_N;
            wait_s2_q <= wait_s1_q;
        end
    end
    assign STATIC_MEM_CTRL_WAIT_N = wait_s2_q;

    ////////////////////////////////////////////////////////////////////
    // direction latch: captured at access start, held to its end
    logic card_acc_q;
    logic rnw_q;

    // hold read-not-write steady for the whole card transfer
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            card_acc_q <= 1'b0;
            rnw_q      <= 1'b1;
        end else begin
            card_acc_q <= card_acc;
            if (card_acc && !card_acc_q)
                rnw_q <= STRB.write_strobe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // strobe steering is combinational so timing matches the controller
    always_comb begin
        PINS = '{oe_rd: 1'b1, we_wr0: 1'b1, ior_wr1: 1'b1, iow_bs3: 1'b1, rnw_cs0: 1'b1};
        if (card_acc) begin
            if (io_like) begin
                // io strobes only, memory write held off; oe held high in io mode, driven low in true ide
                PINS.oe_rd   = (mode == ECNPS_M_IDE) ? 1'b0 : 1'b1;
                PINS.ior_wr1 = STRB.read_strobe_n;
                PINS.iow_bs3 = STRB.write_strobe_n;
            end else begin
                PINS.oe_rd   = STRB.read_strobe_n;
                PINS.we_wr0  = STRB.write_strobe_n;
            end
            // direction taken live on the first cycle, then latched
            PINS.rnw_cs0 = card_acc_q ? rnw_q : STRB.write_strobe_n;
        end else if (!nand_acc) begin
            // other external accesses keep the controller strobes
            PINS.oe_rd   = STRB.read_strobe_n;
            PINS.we_wr0  = STRB.write_strobe_n;
            PINS.ior_wr1 = STRB.upper_write_strobe_n;
            PINS.iow_bs3 = STRB.byte_select_three_n;
            PINS.rnw_cs0 = STRB.chip_select_zero;
        end
    end

    // slot selects follow the chip select timing exactly
    assign CARD_SLOT0_SELECT  = STRB.chip_select_four;
    assign CARD_SLOT1_SELECT  = STRB.chip_select_two;

    // nand strobes and latch enables
    assign NAND_OUTPUT_ENABLE = nand_acc ? STRB.read_strobe_n  : 1'b1;
    assign NAND_WRITE_ENABLE  = nand_acc ? STRB.write_strobe_n : 1'b1;
    assign NAND_ALE           = ADDR[ECNPS_ALE_BIT];
    assign NAND_CLE           = ADDR[ECNPS_CLE_BIT];

    // register select from bit 22, idle high in true ide
    assign CARD_REG_SELECT_N  = (card_acc && mode != ECNPS_M_IDE) ? ADDR[ECNPS_CLE_BIT] : 1'b1;
    assign SDRAM_OWNS_CS1     = SDRAM_ASSIGN_BIT;

    ////////////////////////////////////////////////////////////////////
    // static controller configuration out of reset
    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            CFG_BYTE_SELECT <= ECNPS_RST_BYTE_SELECT;
            CFG_BUS_WIDTH   <= ECNPS_RST_BUS_WIDTH;
            CFG_CS_CTRL_RW  <= ECNPS_RST_CS_CTRL_RW;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_mem_strobes;
        @(posedge REF_CLK) disable iff (!RSTN)
        (card_acc && !io_like) |-> (PINS.oe_rd == STRB.read_strobe_n) && PINS.ior_wr1;
    endproperty
    a_mem_strobes: assert property (p_mem_strobes) else $error("memory mode strobes wrong");

    property p_io_strobes;
        @(posedge REF_CLK) disable iff (!RSTN)
        (card_acc && io_like) |-> PINS.we_wr0 && (PINS.iow_bs3 == STRB.write_strobe_n);
    endproperty
    a_io_strobes: assert property (p_io_strobes) else $error("io mode strobes wrong");

    property p_ide_oe;
        @(posedge REF_CLK) disable iff (!RSTN)
        (card_acc && mode == ECNPS_M_IDE) |-> !PINS.oe_rd;
    endproperty
    a_ide_oe: assert property (p_ide_oe) else $error("ide oe not low");

    sequence s_card_run;
        card_acc ##1 card_acc;
    endsequence
    property p_rnw_stable;
        @(posedge REF_CLK) disable iff (!RSTN)
        s_card_run |-> $stable(PINS.rnw_cs0);
    endproperty
    a_rnw_stable: assert property (p_rnw_stable) else $error("rnw moved in transfer");

    property p_nand_off;
        @(posedge REF_CLK) disable iff (!RSTN)
        (ADDR[31:28] != ECNPS_CS3_NIBBLE) |-> NAND_OUTPUT_ENABLE && NAND_WRITE_ENABLE;
    endproperty
    a_nand_off: assert property (p_nand_off) else $error("nand strobe outside window");

    property p_nand_on;
        @(posedge REF_CLK) disable iff (!RSTN)
        nand_acc |-> NAND_WRITE_ENABLE == STRB.write_strobe_n;
    endproperty
    a_nand_on: assert property (p_nand_on) else $error("nand we not steered");

    property p_wait_sync;
        @(posedge REF_CLK) disable iff (!RSTN)
        ##2 (STATIC_MEM_CTRL_WAIT_N == $past(EXTERNAL_WAIT_N, 2));
    endproperty
    a_wait_sync: assert property (p_wait_sync) else $error("wait not passed through");

    property p_idle_high;
        @(posedge REF_CLK) disable iff (!RSTN)
        (card_acc == 1'b0 && nand_acc) |-> (PINS == 5'h1F);
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("shared pins not idle");

    property p_cle;
        @(posedge REF_CLK) disable iff (!RSTN)
        1'b1 |-> (NAND_CLE == ADDR[22]) && (NAND_ALE == ADDR[21]);
    endproperty
    a_cle: assert property (p_cle) else $error("latch enables wrong");

endmodule // ecnps_steer

/* File: sim/ecnps_card_model.sv */
// card-side model: watches the slot select and may hold its wait line low
// assumes active-low select, sampled on the system clock
`timescale 1ns/1ps
module ecnps_card_model (
    // clock
    input  wire logic REF_CLK,
    // card side
    input  wire logic card_select_n,
    input  wire logic stall_req,
    output logic      wait_n
);
    ////////////////////////////////////////////////////////////////
    // only this model hangs on the slot select pin
    // card reset, irq and detect ride general-purpose lines, left out here
    // wait only while selected, registered, so a stall clears one clock after the select rises
    always_ff @(posedge REF_CLK) begin
        wait_n <= !(stall_req && !card_select_n);
    end
endmodule // ecnps_card_model

/* File: sim/ecnps_steer_tb.sv */
// self-checking bench for the pin steering block
// assumes the card model file is compiled first
`timescale 1ns/1ps
module ecnps_steer_tb;
    import ecnps_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        s0 = 1'b0, s1 = 1'b0, na = 1'b0, sd = 1'b0, stall = 1'b0;
    logic [31:0] addr = 32'h0000_0000;
    ecnps_strb_s strb = 8'hFF;
    ecnps_pins_s pins;
    logic        ewait_n, swait_n, sel0, sel1, noe, nwe, ale, cle, rs_n, owns;
    logic        c_bs, c_rw;
    logic [4:0]  c_bw;
    int          mismatches = 0;
    int          cmp_count = 0;

    ecnps_steer uut (.REF_CLK(ref_clk), .RSTN(rstn), .SLOT0_ASSIGN_BIT(s0),
        .SLOT1_ASSIGN_BIT(s1), .NAND_ASSIGN_BIT(na), .SDRAM_ASSIGN_BIT(sd),
        .ADDR(addr), .STRB(strb), .STATIC_MEM_CTRL_WAIT_N(swait_n), .EXTERNAL_WAIT_N(ewait_n),
        .PINS(pins), .CARD_SLOT0_SELECT(sel0), .CARD_SLOT1_SELECT(sel1),
        .NAND_OUTPUT_ENABLE(noe), .NAND_WRITE_ENABLE(nwe), .NAND_ALE(ale),
        .NAND_CLE(cle), .CARD_REG_SELECT_N(rs_n), .SDRAM_OWNS_CS1(owns),
        .CFG_BYTE_SELECT(c_bs), .CFG_BUS_WIDTH(c_bw), .CFG_CS_CTRL_RW(c_rw));
    ecnps_card_model card (.REF_CLK(ref_clk), .card_select_n(sel0),
        .stall_req(stall), .wait_n(ewait_n));

    ////////////////////////////////////////////////////////////////
    // clock, compare and closing helpers
    always #10 ref_clk = ~ref_clk;
    task automatic chk(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // inputs move 1 ns after the edge, checks 2 ns later once settled
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        chk("cfg", {c_bs, c_bw, c_rw}, {1'b1, 5'h10, 1'b1});
        chk("wait idle", swait_n, 1'b1);
        chk("sdram cs1 off", owns, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_card_modes();
        logic mem, ide, rd, wr;
        s0 = 1'b1;
        for (int m = 0; m < 4; m++) begin
            for (int rw = 0; rw < 2; rw++) begin
                mem = (m < 2);
                ide = (m == 3);
                rd = rw[0];
                wr = !rw[0];
                addr = {4'h5, 3'h0, m[1:0], 1'b0, 22'h0};
                // read, write, then the six other strobes and selects, all high except cs4
                strb = {rd, wr, 6'h3E};
                #2;
                chk("card strobes", {pins.oe_rd, pins.we_wr0, pins.ior_wr1, pins.iow_bs3},
                    {mem ? rd : !ide, mem ? wr : 1'b1, mem | rd, mem | wr});
                chk("reg select", rs_n, ide);
                chk("rnw", pins.rnw_cs0, wr);
                chk("slot0 sel", sel0, 1'b0);
                step(1);
                strb = 8'hFF;
                step(1);
            end
        end
        $display("test card modes done");
    endtask
    task automatic t_rnw_hold();
        // cs4 and read low, then write drops inside the same access
        strb = 8'h7E;
        step(1);
        strb = 8'h3E;
        #2;
        chk("rnw held", pins.rnw_cs0, 1'b1);
        step(1);
        strb = 8'hFF;
        step(1);
        $display("test rnw hold done");
    endtask
    task automatic t_other();
        s0 = 1'b0;
        strb = 8'h5A;
        #2;
        chk("shared pins a", pins, 5'h0B);
        chk("cs4 pin a", sel0, 1'b0);
        step(1);
        addr = 32'h4000_0000;
        strb = 8'hA5;
        #2;
        chk("shared pins b", pins, 5'h14);
        chk("nand off", {noe, nwe}, 2'h3);
        step(1);
        strb = 8'hFF;
        #2;
        chk("idle pins", {pins, sel0, sel1, noe, nwe}, 9'h1FF);
        $display("test other access done");
        step(1);
    endtask
    task automatic t_nand();
        na = 1'b1;
        addr = 32'h4020_0000;
        // chip enable and ready/busy sit on general-purpose lines, never driven
        strb = 8'h7D;
        #2;
        chk("nand rd", {noe, nwe, ale, cle}, 4'h6);
        chk("shared held", pins, 5'h1F);
        step(1);
        addr = 32'h4040_0000;
        strb = 8'hBD;
        #2;
        chk("nand wr", {noe, nwe, ale, cle}, 4'h9);
        step(1);
        addr = 32'h5040_0000;
        #2;
        chk("nand leave", {noe, nwe}, 2'h3);
        step(1);
        strb = 8'hFF;
        na = 1'b0;
        step(1);
        $display("test nand done");
    endtask
    task automatic t_slot1_wait();
        s1 = 1'b1;
        sd = 1'b1;
        addr = 32'h3000_0000;
        // cs1 handed to sdram first; its bus width stays a software setting
        strb = 8'h7B;
        #2;
        chk("slot1 sel", {sel1, pins.oe_rd}, 2'h0);
        chk("sdram cs1", owns, 1'b1);
        step(1);
        s1 = 1'b0;
        s0 = 1'b1;
        addr = 32'h5000_0000;
        strb = 8'hFE;
        stall = 1'b1;
        step(4);
        chk("wait on", swait_n, 1'b0);
        stall = 1'b0;
        step(4);
        chk("wait off", swait_n, 1'b1);
        strb = 8'hFF;
        $display("test slot1 and wait done");
    endtask

    ////////////////////////////////////////////////////////////////
    // main sequence and watchdog
    initial begin
        step(4);
        rstn = 1'b1;
        step(1);
        t_reset();
        t_card_modes();
        t_rnw_hold();
        t_other();
        t_nand();
        t_slot1_wait();
        report_and_stop();
    end
    initial begin
        #40000;
        mismatches++;
        report_and_stop();
    end
endmodule // ecnps_steer_tb
